/* pkg/srnv_pkg.sv */
// Package of constants and carriers for the reset and NMI vector block
// Functional notes
// [RULE_01] Reset vector: zero idle, brownout 0x02 highest
// [RULE_02] Brownout causes coded 04,06,08,0A,0E
// [RULE_03] Software power-on request reads 0x14
// [RULE_04] Watchdog 16, watchdog key 18, memctl 1A
// [RULE_05] Memory uncorrectable 1C, peripheral fetch 1E
// [RULE_06] Power key 20, lock loss 24
// [RULE_07] System NMI: low-power reset 02, memory 04
// [RULE_08] Vacant 12, mailbox in 14, out 16
// [RULE_09] Correctable memory error reads 0x18
// [RULE_10] User NMI: pin 02, oscillator fault 04
// [RULE_11] Vectors at 0x15e, 0x15c, 0x15a
// [RULE_12] Serial pins on P1[7:4] or P1[3:0]
// [RULE_13] Capture inputs from P1[7:6] or P2[1:0]
// [RULE_14] PWM reaches both groups, select gates pin
// [RULE_15] Trigger select comparator or P1.2, tristate
// [RULE_16] Timer output modulates serial transmit for infrared
// [RULE_17] Mailbox with in and out events
// [RULE_18] Vector read clears the reported source
// [RULE_19] Reserved codes are never returned
package srnv_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] SRNV_OFS_USER_NMI = 16'h015a;
   localparam logic [15:0] SRNV_OFS_SYS_NMI = 16'h015c;
   localparam logic [15:0] SRNV_OFS_RESET = 16'h015e;
   localparam logic [15:0] SRNV_OFS_CFG1 = 16'h0162;
   localparam logic [15:0] SRNV_OFS_CFG3 = 16'h0166;
   localparam logic [15:0] SRNV_OFS_MBOX_IN = 16'h0148;
   localparam logic [15:0] SRNV_OFS_MBOX_OUT = 16'h014c;
   localparam logic [15:0] SRNV_OFS_IRQ_STAT = 16'h0170;
   localparam logic [15:0] SRNV_OFS_IRQ_MASK = 16'h0172;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int SRNV_CFG1_IR_EN = 0;
   localparam int SRNV_CFG1_IR_POL = 1;
   localparam int SRNV_CFG1_IR_MODE = 2;
   localparam int SRNV_CFG1_IR_DSRC = 3;
   localparam int SRNV_CFG1_IR_DATA = 4;
   localparam int SRNV_CFG3_SER_RMP = 0;
   localparam int SRNV_CFG3_TMR_RMP = 1;
   localparam int SRNV_CFG3_TRG_SEL = 2;
   localparam logic [15:0] SRNV_CFG_RESET = 16'h0000;
   localparam logic [15:0] SRNV_MASK_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // Vector codes, index i of a source table gives code 2*(i+1)
   // ---------------------------------------------------------------
   localparam int SRNV_RST_N = 18;
   localparam int SRNV_SNMI_N = 12;
   localparam int SRNV_UNMI_N = 2;
   // Reset cause codes; zero entries are reserved slots
   localparam logic [15:0] SRNV_RST_CODES [SRNV_RST_N] = '{
      16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h0000,
      16'h000e, 16'h0000, 16'h0000, 16'h0014, 16'h0016, 16'h0018,
      16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0000, 16'h0024};
   localparam logic [SRNV_RST_N-1:0] SRNV_RST_VALID = 18'h2fe5f;
   localparam logic [SRNV_SNMI_N-1:0] SRNV_SNMI_VALID = 12'hf03;
   localparam logic [SRNV_UNMI_N-1:0] SRNV_UNMI_VALID = 2'h3;
   // Status bits of the interrupt register
   localparam int SRNV_IRQ_SNMI = 0;
   localparam int SRNV_IRQ_UNMI = 1;
   localparam int SRNV_IRQ_MBOX = 2;
   localparam int SRNV_IRQ_W = 3;
   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } srnv_bus_t;
   typedef struct packed {
      logic [3:0] ser_out;
      logic [3:0] ser_oe;
      logic [1:0] cap;
   } srnv_route_t;
endpackage : srnv_pkg

/* rtl/srnv_prio.sv */
// Priority encoder with read-to-clear pending flags
`timescale 1ns/1ps
module srnv_prio #(
   parameter int N = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [N-1:0] set,
   input wire logic [N-1:0] valid,
   input wire logic rd_clr,
   output logic [N-1:0] pend,
   output logic [15:0] code
);
   import srnv_pkg::*;
   // Lowest pending index wins; codes are 2*(index+1)
   function automatic logic [15:0] enc(input logic [N-1:0] p);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = N - 1; i >= 0; i--) begin
         if (p[i]) begin
            r = 16'((i + 1) * 2);
         end
      end
      return r;
   endfunction : enc
   logic [N-1:0] pend_q;
   logic [N-1:0] top;
   // Reserved slots never latch, so reserved codes never show
   always_comb begin
      top = pend_q & ~(pend_q - N'(1)); // one-hot of lowest set
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= '0;
      end else begin
         // New events win over the read clear
         pend_q <= ((pend_q & ~(rd_clr ? top : '0)) | set) & valid; // see [RULE_18] see [RULE_19]
      end
   end
   assign pend = pend_q;
   assign code = enc(pend_q); // see [RULE_01] see [RULE_07] see [RULE_10]
endmodule : srnv_prio

/* rtl/srnv_top.sv */
// Reset-cause and NMI vector generator with system routing controls
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module srnv_top (
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire srnv_pkg::srnv_bus_t bus,
   output logic [15:0] rdata,
   // Reset cause, system NMI and user NMI events, pulses or levels
   input wire logic [srnv_pkg::SRNV_RST_N-1:0] reset_events,
   input wire logic [srnv_pkg::SRNV_SNMI_N-1:0] sys_nmi_events,
   input wire logic [srnv_pkg::SRNV_UNMI_N-1:0] user_nmi_events,
   // Debug link mailbox side
   input wire logic [15:0] dbg_mbox_wdata,
   input wire logic dbg_mbox_wr,
   input wire logic dbg_mbox_rd,
   output logic [15:0] dbg_mbox_rdata,
   // Serial and timer routing
   input wire logic [3:0] ser_tx_sig,
   input wire logic [3:0] ser_tx_oe,
   input wire logic [1:0] pwm_out,
   input wire logic [7:0] p1_pin,
   input wire logic [1:0] p2_pin,
   input wire logic [1:0] p1_func_sel,
   input wire logic [1:0] p2_func_sel,
   input wire logic comp_out,
   output logic [3:0] p1_hi_out,
   output logic [3:0] p1_hi_oe,
   output logic [3:0] p1_lo_out,
   output logic [3:0] p1_lo_oe,
   output logic [1:0] cap_in,
   output logic [1:0] p1_pwm_out,
   output logic [1:0] p1_pwm_oe,
   output logic [1:0] p2_pwm_out,
   output logic [1:0] p2_pwm_oe,
   output logic timer_output_hiz,
   output logic irq
);
   import srnv_pkg::*;
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] rdata;
      logic [15:0] cfg1;
      logic [15:0] cfg3;
      logic [15:0] mbox_in;
      logic [15:0] mbox_out;
      logic [SRNV_IRQ_W-1:0] stat;
      logic [SRNV_IRQ_W-1:0] mask;
      logic trg_s; // Filtered trigger pin
      logic [7:0] p1_s1;
      logic [7:0] p1_s2;
      logic [7:0] p1_s3;
      logic [1:0] p2_s1;
      logic [1:0] p2_s2;
      logic [1:0] p2_s3;
      logic [1:0] p1_f;
      logic [1:0] p2_f;
      srnv_route_t route;
      logic [3:0] lo_out;
      logic [3:0] lo_oe;
      logic [1:0] p1p;
      logic [1:0] p1e;
      logic [1:0] p2p;
      logic [1:0] p2e;
      logic hiz;
      logic irq;
      logic mb_in_ev;
      logic mb_out_ev;
   } srnv_state_t;
   srnv_state_t s_q, s_d;
   logic rd_rst, rd_snmi, rd_unmi;
   logic [SRNV_RST_N-1:0] rst_pend;
   logic [SRNV_SNMI_N-1:0] snmi_pend;
   logic [SRNV_UNMI_N-1:0] unmi_pend;
   logic [15:0] rst_code, snmi_code, unmi_code;
   logic [SRNV_SNMI_N-1:0] snmi_set;
   // ---------------------------------------------------------------
   // Vector decode, a read consumes the top source
   // ---------------------------------------------------------------
   always_comb begin
      rd_rst = bus.rd && bus.addr == SRNV_OFS_RESET; // see [RULE_11]
      rd_snmi = bus.rd && bus.addr == SRNV_OFS_SYS_NMI; // see [RULE_11]
      rd_unmi = bus.rd && bus.addr == SRNV_OFS_USER_NMI; // see [RULE_11]
      snmi_set = sys_nmi_events;
      snmi_set[9] = sys_nmi_events[9] | s_q.mb_in_ev; // see [RULE_17] see [RULE_08]
      snmi_set[10] = sys_nmi_events[10] | s_q.mb_out_ev; // see [RULE_17] see [RULE_08]
   end
   // Reset causes; codes follow table layout
   srnv_prio #(.N(SRNV_RST_N)) u_rst (
      .clk(clk), .reset_n(reset_n), .set(reset_events), .valid(SRNV_RST_VALID),
      .rd_clr(rd_rst), .pend(rst_pend), .code(rst_code)
   ); // see [RULE_02] see [RULE_03] see [RULE_04] see [RULE_05] see [RULE_06]
   srnv_prio #(.N(SRNV_SNMI_N)) u_snmi (
      .clk(clk), .reset_n(reset_n), .set(snmi_set), .valid(SRNV_SNMI_VALID),
      .rd_clr(rd_snmi), .pend(snmi_pend), .code(snmi_code)
   ); // see [RULE_09]
   srnv_prio #(.N(SRNV_UNMI_N)) u_unmi (
      .clk(clk), .reset_n(reset_n), .set(user_nmi_events), .valid(SRNV_UNMI_VALID),
      .rd_clr(rd_unmi), .pend(unmi_pend), .code(unmi_code)
   );
   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic trg;
      logic ir_d;
      logic ir_m;
      logic [SRNV_IRQ_W-1:0] ev;
      trg = 1'b0;
      ir_d = 1'b0;
      ir_m = 1'b0;
      ev = '0;
      s_d = s_q;
      // Pin synchronisers; stage 1 feeds only stage 2
      s_d.p1_s1 = p1_pin;
      s_d.p1_s2 = s_q.p1_s1;
      s_d.p1_s3 = s_q.p1_s2;
      s_d.p2_s1 = p2_pin;
      s_d.p2_s2 = s_q.p2_s1;
      s_d.p2_s3 = s_q.p2_s2;
      // Change accepted once stages 2 and 3 agree
      for (int i = 0; i < 2; i++) begin
         if (s_q.p1_s2[6+i] == s_q.p1_s3[6+i]) begin
            s_d.p1_f[i] = s_q.p1_s2[6+i];
         end
         if (s_q.p2_s2[i] == s_q.p2_s3[i]) begin
            s_d.p2_f[i] = s_q.p2_s2[i];
         end
      end
      if (s_q.p1_s2[2] == s_q.p1_s3[2]) begin
         s_d.trg_s = s_q.p1_s2[2];
      end
      // Read data, one cycle after the strobe
      s_d.rdata = 16'h0000;
      if (bus.rd) begin
         unique case (bus.addr)
            SRNV_OFS_RESET: s_d.rdata = rst_code;
            SRNV_OFS_SYS_NMI: s_d.rdata = snmi_code;
            SRNV_OFS_USER_NMI: s_d.rdata = unmi_code;
            SRNV_OFS_CFG1: s_d.rdata = s_q.cfg1;
            SRNV_OFS_CFG3: s_d.rdata = s_q.cfg3;
            SRNV_OFS_MBOX_IN: s_d.rdata = s_q.mbox_in;
            SRNV_OFS_MBOX_OUT: s_d.rdata = s_q.mbox_out;
            SRNV_OFS_IRQ_STAT: s_d.rdata = 16'(s_q.stat);
            SRNV_OFS_IRQ_MASK: s_d.rdata = 16'(s_q.mask);
            default: s_d.rdata = 16'h0000;
         endcase
      end
      // Mailbox: debug writes inbox, application writes outbox
      s_d.mb_in_ev = dbg_mbox_wr; // see [RULE_17]
      s_d.mb_out_ev = bus.wr && bus.addr == SRNV_OFS_MBOX_OUT; // see [RULE_17]
      if (dbg_mbox_wr) begin
         s_d.mbox_in = dbg_mbox_wdata;
      end
      // Writes
      if (bus.wr) begin
         unique case (bus.addr)
            SRNV_OFS_CFG1: s_d.cfg1 = bus.wdata;
            SRNV_OFS_CFG3: s_d.cfg3 = bus.wdata;
            SRNV_OFS_MBOX_OUT: s_d.mbox_out = bus.wdata;
            SRNV_OFS_IRQ_MASK: s_d.mask = bus.wdata[SRNV_IRQ_W-1:0];
            default: ;
         endcase
      end
      // Sticky status; set wins over write-one-clear
      ev[SRNV_IRQ_SNMI] = |snmi_pend;
      ev[SRNV_IRQ_UNMI] = |unmi_pend;
      ev[SRNV_IRQ_MBOX] = dbg_mbox_rd;
      if (bus.wr && bus.addr == SRNV_OFS_IRQ_STAT) begin
         s_d.stat = s_q.stat & ~bus.wdata[SRNV_IRQ_W-1:0];
      end
      s_d.stat = s_d.stat | ev;
      s_d.irq = |(s_d.stat & s_d.mask);
      // Serial remap: only one group drives at a time
      if (s_q.cfg3[SRNV_CFG3_SER_RMP]) begin // see [RULE_12]
         s_d.lo_out = ser_tx_sig;
         s_d.lo_oe = ser_tx_oe;
         s_d.route.ser_out = 4'h0;
         s_d.route.ser_oe = 4'h0;
      end else begin
         s_d.lo_out = 4'h0;
         s_d.lo_oe = 4'h0;
         s_d.route.ser_out = ser_tx_sig;
         s_d.route.ser_oe = ser_tx_oe;
      end
      // Infrared modulation of transmit (bit 3 of the group selected by the serial remap)
      if (s_q.cfg1[SRNV_CFG1_IR_EN]) begin // see [RULE_16]
         ir_d = s_q.cfg1[SRNV_CFG1_IR_DSRC] ? s_q.cfg1[SRNV_CFG1_IR_DATA] : ser_tx_sig[3];
         ir_m = s_q.cfg1[SRNV_CFG1_IR_MODE] ? (ir_d ? pwm_out[0] : pwm_out[1])
                                            : (ir_d & pwm_out[0]);
         ir_m = ir_m ^ s_q.cfg1[SRNV_CFG1_IR_POL];
         if (s_q.cfg3[SRNV_CFG3_SER_RMP]) begin
            s_d.lo_out[3] = ir_m;
         end else begin
            s_d.route.ser_out[3] = ir_m;
         end
      end
      // Capture source by timer remap
      s_d.route.cap = s_q.cfg3[SRNV_CFG3_TMR_RMP] ? s_q.p2_f : s_q.p1_f; // see [RULE_13]
      // High-impedance trigger source
      trg = s_q.cfg3[SRNV_CFG3_TRG_SEL] ? s_q.trg_s : comp_out; // see [RULE_15]
      s_d.hiz = trg;
      // PWM to both groups, enables gated by function select and by the tristate trigger
      s_d.p1p = pwm_out; // see [RULE_14]
      s_d.p2p = pwm_out; // see [RULE_14]
      s_d.p1e = trg ? 2'h0 : p1_func_sel; // see [RULE_14] see [RULE_15]
      s_d.p2e = trg ? 2'h0 : p2_func_sel; // see [RULE_14] see [RULE_15]
   end
   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.cfg1 <= SRNV_CFG_RESET;
         s_q.cfg3 <= SRNV_CFG_RESET;
         s_q.mask <= SRNV_MASK_RESET[SRNV_IRQ_W-1:0];
      end else begin
         s_q <= s_d;
      end
   end
   // Outputs straight from flops
   assign rdata = s_q.rdata;
   assign dbg_mbox_rdata = s_q.mbox_out;
   assign p1_hi_out = s_q.route.ser_out;
   assign p1_hi_oe = s_q.route.ser_oe;
   assign p1_lo_out = s_q.lo_out;
   assign p1_lo_oe = s_q.lo_oe;
   assign cap_in = s_q.route.cap;
   assign p1_pwm_out = s_q.p1p;
   assign p1_pwm_oe = s_q.p1e;
   assign p2_pwm_out = s_q.p2p;
   assign p2_pwm_oe = s_q.p2e;
   assign timer_output_hiz = s_q.hiz;
   assign irq = s_q.irq;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_rst_read;
      bus.rd && bus.addr == SRNV_OFS_RESET;
   endsequence
   a_rst_vec_read: assert property (s_rst_read |=> rdata == $past(rst_code)) // see [RULE_01]
      else $error("reset vector read data wrong");
   a_rst_idle_zero: assert property (rst_pend == '0 |-> rst_code == 16'h0000) // see [RULE_01]
      else $error("idle reset vector not zero");
   a_bor_first: assert property (rst_pend[0] |-> rst_code == 16'h0002) // see [RULE_01]
      else $error("brownout not highest");
   a_swpor_code: assert property (rst_pend[8:0] == '0 && rst_pend[9] |-> rst_code == 16'h0014) // see [RULE_03]
      else $error("software power-on code wrong");
   a_wdt_code: assert property (rst_pend[9:0] == '0 && rst_pend[10] |-> rst_code == 16'h0016) // see [RULE_04]
      else $error("watchdog code wrong");
   a_rst_no_res: assert property (rst_code != 16'h000c && rst_code != 16'h0010 && rst_code != 16'h0012 && rst_code != 16'h0022 && rst_code <= 16'h0024) // see [RULE_19]
      else $error("reserved reset code returned");
   a_read_clears: assert property (s_rst_read ##0 rst_pend[0] && !reset_events[0] |=> !rst_pend[0]) // see [RULE_18]
      else $error("read did not clear source");
   a_mbox_event: assert property (dbg_mbox_wr ##1 1'b1 |=> snmi_pend[9]) // see [RULE_17]
      else $error("mailbox input not pending");
   a_vmai_code: assert property (snmi_pend[7:0] == '0 && snmi_pend[8] |-> snmi_code == 16'h0012) // see [RULE_08]
      else $error("vacant access code wrong");
   a_unmi_top: assert property (unmi_pend[0] |-> unmi_code == 16'h0002) // see [RULE_10]
      else $error("user nmi top code wrong");
   a_cap_route: assert property (s_q.cfg3[SRNV_CFG3_TMR_RMP] |=> cap_in == $past(s_q.p2_f)) // see [RULE_13]
      else $error("capture remap wrong");
   a_hiz_gate: assert property (timer_output_hiz |-> p1_pwm_oe == 2'h0 && p2_pwm_oe == 2'h0) // see [RULE_15]
      else $error("pwm pads not released");
endmodule : srnv_top

/* testbench/tb_system_reset_nmi_vectors.sv */
// Self-checking testbench for the reset and NMI vector block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_system_reset_nmi_vectors;
   import srnv_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic clk = 1'b0; // 20 MHz system clock
   logic reset_n = 1'b0; // Held low at start
   srnv_bus_t bus = '0; // Register port request
   logic [15:0] rdata;
   logic [SRNV_RST_N-1:0] reset_events = '0;
   logic [SRNV_SNMI_N-1:0] sys_nmi_events = '0;
   logic [SRNV_UNMI_N-1:0] user_nmi_events = '0;
   logic [15:0] dbg_mbox_wdata = '0;
   logic dbg_mbox_wr = 1'b0;
   logic dbg_mbox_rd = 1'b0;
   logic [15:0] dbg_mbox_rdata;
   logic [3:0] ser_tx_sig = 4'ha; // TX bit high, distinct pattern
   logic [3:0] ser_tx_oe = 4'h5;
   logic [1:0] pwm_out = '0;
   logic [7:0] p1_pin = '0;
   logic [1:0] p2_pin = '0;
   logic [1:0] p1_func_sel = '0;
   logic [1:0] p2_func_sel = '0;
   logic comp_out = 1'b0;
   logic [3:0] p1_hi_out, p1_hi_oe, p1_lo_out, p1_lo_oe;
   logic [1:0] cap_in, p1_pwm_out, p1_pwm_oe, p2_pwm_out, p2_pwm_oe;
   logic timer_output_hiz, irq;
   int fails = 0; // Mismatch count
   int checked = 0; // Comparison count
   // ---------------------------------------------------------------
   // Device under test
   // ---------------------------------------------------------------
   srnv_top i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
      .reset_events(reset_events), .sys_nmi_events(sys_nmi_events),
      .user_nmi_events(user_nmi_events), .dbg_mbox_wdata(dbg_mbox_wdata),
      .dbg_mbox_wr(dbg_mbox_wr), .dbg_mbox_rd(dbg_mbox_rd), .dbg_mbox_rdata(dbg_mbox_rdata),
      .ser_tx_sig(ser_tx_sig), .ser_tx_oe(ser_tx_oe), .pwm_out(pwm_out), .p1_pin(p1_pin),
      .p2_pin(p2_pin), .p1_func_sel(p1_func_sel), .p2_func_sel(p2_func_sel),
      .comp_out(comp_out), .p1_hi_out(p1_hi_out), .p1_hi_oe(p1_hi_oe),
      .p1_lo_out(p1_lo_out), .p1_lo_oe(p1_lo_oe), .cap_in(cap_in), .p1_pwm_out(p1_pwm_out),
      .p1_pwm_oe(p1_pwm_oe), .p2_pwm_out(p2_pwm_out), .p2_pwm_oe(p2_pwm_oe),
      .timer_output_hiz(timer_output_hiz), .irq(irq));
   // ---------------------------------------------------------------
   // Clock, reset and hang guard
   // ---------------------------------------------------------------
   // Half period of 25 ns
   initial begin
      forever #25 clk = ~clk;
   end
   // Bounded guard: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // Bus and helper tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // One-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] ex);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      `CHK(nm, ex, rdata)
   endtask : rd_chk
   // Pulse one event group for a single cycle, then let flags settle
   task automatic fire(input int which, input logic [17:0] m);
      @(posedge clk);
      case (which)
         0: reset_events <= m;
         1: sys_nmi_events <= m[11:0];
         default: user_nmi_events <= m[1:0];
      endcase
      @(posedge clk);
      reset_events <= '0;
      sys_nmi_events <= '0;
      user_nmi_events <= '0;
      tick(2);
   endtask : fire
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Reset values, unmapped place, ignored vector write
   task automatic t_regs;
      rd_chk("cfg1", SRNV_OFS_CFG1, 16'h0000);
      rd_chk("cfg3", SRNV_OFS_CFG3, 16'h0000);
      rd_chk("mask", SRNV_OFS_IRQ_MASK, 16'h0000);
      rd_chk("unmapped", 16'h0150, 16'h0000);
      rd_chk("rst_idle", SRNV_OFS_RESET, 16'h0000);
      wr(SRNV_OFS_RESET, 16'hffff);
      rd_chk("rst_wr", SRNV_OFS_RESET, 16'h0000);
      rd_chk("snmi_idle", SRNV_OFS_SYS_NMI, 16'h0000);
      rd_chk("unmi_idle", SRNV_OFS_USER_NMI, 16'h0000);
      $display("test regs done");
   endtask : t_regs
   // Every reset slot alone; reserved slots read zero
   task automatic t_reset_codes;
      for (int i = 0; i < SRNV_RST_N; i++) begin
         fire(0, 18'h1 << i);
         // Table holds zero for reserved slots
         rd_chk("rst_code", SRNV_OFS_RESET, SRNV_RST_CODES[i]);
         rd_chk("rst_clear", SRNV_OFS_RESET, 16'h0000);
      end
      // Several pending: drained in priority order
      fire(0, 18'h20241);
      rd_chk("rst_p0", SRNV_OFS_RESET, 16'h0002);
      rd_chk("rst_p1", SRNV_OFS_RESET, 16'h000e);
      rd_chk("rst_p2", SRNV_OFS_RESET, 16'h0014);
      rd_chk("rst_p3", SRNV_OFS_RESET, 16'h0024);
      rd_chk("rst_p4", SRNV_OFS_RESET, 16'h0000);
      $display("test reset codes done");
   endtask : t_reset_codes
   // System and user NMI codes with priority
   task automatic t_nmi_codes;
      logic [15:0] ex;
      for (int i = 0; i < SRNV_SNMI_N; i++) begin
         fire(1, 18'h1 << i);
         ex = (i < 2 || i > 7) ? 16'(2 * (i + 1)) : 16'h0000;
         rd_chk("snmi_code", SRNV_OFS_SYS_NMI, ex);
      end
      fire(1, 18'h00f03);
      rd_chk("snmi_p0", SRNV_OFS_SYS_NMI, 16'h0002);
      rd_chk("snmi_p1", SRNV_OFS_SYS_NMI, 16'h0004);
      rd_chk("snmi_p2", SRNV_OFS_SYS_NMI, 16'h0012);
      rd_chk("snmi_p3", SRNV_OFS_SYS_NMI, 16'h0014);
      rd_chk("snmi_p4", SRNV_OFS_SYS_NMI, 16'h0016);
      rd_chk("snmi_p5", SRNV_OFS_SYS_NMI, 16'h0018);
      rd_chk("snmi_p6", SRNV_OFS_SYS_NMI, 16'h0000);
      fire(2, 18'h3);
      rd_chk("unmi_p0", SRNV_OFS_USER_NMI, 16'h0002);
      rd_chk("unmi_p1", SRNV_OFS_USER_NMI, 16'h0004);
      rd_chk("unmi_p2", SRNV_OFS_USER_NMI, 16'h0000);
      $display("test nmi codes done");
   endtask : t_nmi_codes
   // Serial pin group and capture input remapping
   task automatic t_remap;
      @(posedge clk);
      p1_pin <= 8'h40;
      p2_pin <= 2'h2;
      wr(SRNV_OFS_CFG3, 16'h0000);
      tick(6);
      `CHK("hi_out", 4'ha, p1_hi_out)
      `CHK("hi_oe", 4'h5, p1_hi_oe)
      `CHK("lo_oe_off", 4'h0, p1_lo_oe)
      `CHK("cap_p1", 2'h1, cap_in)
      wr(SRNV_OFS_CFG3, 16'h0003);
      tick(6);
      `CHK("lo_out", 4'ha, p1_lo_out)
      `CHK("lo_oe", 4'h5, p1_lo_oe)
      `CHK("hi_oe_off", 4'h0, p1_hi_oe)
      `CHK("cap_p2", 2'h2, cap_in)
      wr(SRNV_OFS_CFG3, 16'h0000);
      $display("test remap done");
   endtask : t_remap
   // PWM copies and the tristate trigger from both sources
   task automatic t_hiz;
      pwm_out <= 2'b10;
      p1_func_sel <= 2'b11;
      p2_func_sel <= 2'b01;
      wr(SRNV_OFS_CFG3, 16'h0002);
      tick(6);
      `CHK("hiz_off", 1'b0, timer_output_hiz)
      `CHK("p1_pwm", 2'h2, p1_pwm_out)
      `CHK("p2_pwm", 2'h2, p2_pwm_out)
      `CHK("p1_pwm_oe", 2'h3, p1_pwm_oe)
      `CHK("p2_pwm_oe", 2'h1, p2_pwm_oe)
      comp_out <= 1'b1;
      tick(3);
      `CHK("hiz_comp", 1'b1, timer_output_hiz)
      `CHK("p1_oe_hiz", 2'h0, p1_pwm_oe)
      `CHK("p2_oe_hiz", 2'h0, p2_pwm_oe)
      wr(SRNV_OFS_CFG3, 16'h0004);
      tick(6);
      `CHK("hiz_pin_lo", 1'b0, timer_output_hiz)
      p1_pin <= 8'h44;
      tick(6);
      `CHK("hiz_pin_hi", 1'b1, timer_output_hiz)
      comp_out <= 1'b0;
      p1_pin <= 8'h00;
      wr(SRNV_OFS_CFG3, 16'h0000);
      $display("test hiz done");
   endtask : t_hiz
   // Infrared modulation of the transmit pin, six rows over mode, polarity and data source
   task automatic t_ir;
      logic [1:0] pw [6] = '{2'b01, 2'b00, 2'b01, 2'b10, 2'b10, 2'b01};
      logic [15:0] cf [6] = '{16'h0019, 16'h0019, 16'h001b, 16'h000d, 16'h001d, 16'h0001};
      logic ex [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++) begin
         pwm_out <= pw[i];
         wr(SRNV_OFS_CFG1, cf[i]);
         tick(3);
         `CHK("ir_tx", ex[i], p1_hi_out[3])
      end
      // Remapped group; idle timer output makes the modulated bit differ from raw TX
      pwm_out <= 2'h0;
      wr(SRNV_OFS_CFG3, 16'h0001);
      tick(3);
      `CHK("ir_tx_lo", 1'b0, p1_lo_out[3])
      `CHK("ir_hi_off", 4'h0, p1_hi_out)
      wr(SRNV_OFS_CFG3, 16'h0000);
      wr(SRNV_OFS_CFG1, 16'h0000);
      $display("test ir done");
   endtask : t_ir
   // Mailbox both ways, its events, and the interrupt path
   task automatic t_mbox_irq;
      @(posedge clk);
      dbg_mbox_wdata <= 16'h5a3c;
      dbg_mbox_wr <= 1'b1;
      @(posedge clk);
      dbg_mbox_wr <= 1'b0;
      tick(3);
      rd_chk("mbox_in", SRNV_OFS_MBOX_IN, 16'h5a3c);
      rd_chk("mbox_in_ev", SRNV_OFS_SYS_NMI, 16'h0014);
      wr(SRNV_OFS_MBOX_OUT, 16'hc3a5);
      tick(3);
      `CHK("mbox_out", 16'hc3a5, dbg_mbox_rdata)
      rd_chk("mbox_out_ev", SRNV_OFS_SYS_NMI, 16'h0016);
      wr(SRNV_OFS_IRQ_STAT, 16'h0007);
      wr(SRNV_OFS_IRQ_MASK, 16'h0004);
      @(posedge clk);
      dbg_mbox_rd <= 1'b1;
      @(posedge clk);
      dbg_mbox_rd <= 1'b0;
      tick(3);
      rd_chk("stat", SRNV_OFS_IRQ_STAT, 16'h0004);
      `CHK("irq_on", 1'b1, irq)
      wr(SRNV_OFS_IRQ_MASK, 16'h0000);
      tick(2);
      `CHK("irq_masked", 1'b0, irq)
      wr(SRNV_OFS_IRQ_MASK, 16'h0004);
      wr(SRNV_OFS_IRQ_STAT, 16'h0004);
      tick(2);
      `CHK("irq_cleared", 1'b0, irq)
      $display("test mailbox and irq done");
   endtask : t_mbox_irq
   // ---------------------------------------------------------------
   // Verdict, the only place the run ends
   // ---------------------------------------------------------------
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_reset_codes();
      t_nmi_codes();
      t_remap();
      t_hiz();
      t_ir();
      t_mbox_irq();
      end_of_test();
   end
endmodule : tb_system_reset_nmi_vectors
